/* dcrc_pkg.sv */
/*
 * Package for the buck regulator control register block: offsets, field
 * positions, reset values and operating modes.
 * Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
 */
package dcrc_pkg;

    // ************************************************************
    // Register byte offsets.
    // ************************************************************
    localparam logic [11:0] ZDET_OFFSET   = 12'h050;
    localparam logic [11:0] CLIM_OFFSET   = 12'h054;
    localparam logic [11:0] COMP_OFFSET   = 12'h058;
    localparam logic [11:0] LNV_OFFSET    = 12'h05c;
    localparam logic [11:0] TIMING_OFFSET = 12'h060;
    localparam logic [11:0] MODE_OFFSET   = 12'h064;

    // ************************************************************
    // Field positions (low bit) and reset values.
    // ************************************************************
    localparam int ZDET_LEVEL_LSB = 4;
    localparam int ZDET_BLANK_LSB = 8;
    localparam logic [2:0] ZDET_LEVEL_RESET = 3'h3;
    localparam logic [1:0] ZDET_BLANK_RESET = 2'h1;

    localparam int CLIM_BLANK_LSB = 8;
    localparam int CLIM_BYP_BIT   = 13;
    localparam logic [1:0] CLIM_BLANK_RESET = 2'h1;
    localparam logic       CLIM_BYP_RESET   = 1'b1;

    localparam int COMP_C3_LSB = 28;
    localparam int COMP_C2_LSB = 24;
    localparam int COMP_C1_LSB = 20;
    localparam int COMP_R3_LSB = 12;
    localparam int COMP_R2_LSB = 4;
    localparam int COMP_R1_LSB = 0;
    localparam logic [3:0] COMP_C3_RESET = 4'h5;
    localparam logic [2:0] COMP_C2_RESET = 3'h7;
    localparam logic [1:0] COMP_C1_RESET = 2'h2;
    localparam logic [3:0] COMP_R3_RESET = 4'h4;
    localparam logic [4:0] COMP_R2_RESET = 5'h07;
    localparam logic [2:0] COMP_R1_RESET = 3'h7;

    localparam int LNV_REF_LSB = 8;
    localparam int LNV_ATT_BIT = 1;
    localparam logic [6:0] LNV_REF_RESET = 7'h71;
    localparam logic       LNV_ATT_RESET = 1'b0;

    localparam int TIM_DUTY_LSB   = 29;
    localparam int TIM_BYP_LSB    = 20;
    localparam int TIM_LN_LSB     = 12;
    localparam int TIM_PRCHG_BIT  = 11;
    localparam int TIM_LPINIT_LSB = 0;
    localparam logic [1:0] TIM_DUTY_RESET   = 2'h0;
    localparam logic [7:0] TIM_BYP_RESET    = 8'hff;
    localparam logic [4:0] TIM_LN_RESET     = 5'h1f;
    localparam logic       TIM_PRCHG_RESET  = 1'b1;
    localparam logic [7:0] TIM_LPINIT_RESET = 8'hff;

    localparam int MODE_CCM_BIT   = 0;
    localparam int MODE_LP_BIT    = 1;
    localparam logic MODE_CCM_RESET = 1'b0;
    localparam logic MODE_LP_RESET  = 1'b0;

    // ************************************************************
    // Zero detector behaviour and bus transfer codes.
    // ************************************************************
    typedef enum logic [1:0] {
        DCRC_ZD_CROSSING = 2'b01,
        DCRC_ZD_LIMITER  = 2'b10
    } dcrc_zdet_type;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;

endpackage

/* dcrc_regs.sv */
/*
 * Buck regulator control registers on AHB-Lite, with the derived controls
 * that steer the zero detector, current limiter and low-noise loop.
 * Assumes one AHB-Lite master, a 50 MHz clk, and that rst is asserted only
 * by power-on, hard pin or brown-out reset.
 */
//
// Functional notes
// R1 - With force-continuous clear in low-noise operation the zero detector only detects crossings.
// R2 - With force-continuous set in low-noise operation the detector limits reverse current at the level field.
// R3 - In low-power operation the detector is always a zero-crossing detector.
// R4 - The level field is bits 6:4, resets to 3, and the effective limit is zero while force-continuous is clear.
// R5 - Force-continuous set with level zero behaves as discontinuous conduction.
// R6 - Software computes the level from allowed reverse current, ripple and switch count.
// R7 - Capacitor trims C3 at 31:28 reset 5, C2 at 26:24 and C1 at 21:20 are read-write.
// R8 - Resistor trims R3 at 15:12 reset 4, R2 at 8:4 and R1 at 2:0 are read-write.
// R9 - The reference trim at 14:8 resets to 0x71 and is writable by software and hardware.
// R10 - The output target is set jointly by the attenuation bit and the reference trim.
// R11 - The attenuation bit picks ratio one third when clear and one sixth when set, reset clear.
// R12 - All fields return to reset values only on power-on, pin or brown-out reset.
// R13 - Software writes zero to reserved bits.
// R14 - Software leaves the internal-use fields at reset, and the device holds them; here the blanking delays and precharge enable take any write.
`timescale 1ns/10ps

module dcrc_regs
    import dcrc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        refTrimLoad,
    input  wire logic [6:0]  refTrimValue,
    output dcrc_zdet_type    zeroDetectMode,
    output logic      [2:0]  reverseCurrentLimit,
    output logic             continuousConduction,
    output logic             bypassCurrentLimitOn,
    output logic      [1:0]  zeroDetectBlankDelay,
    output logic      [1:0]  currentLimitBlankDelay,
    output logic      [3:0]  compCapTrimThree,
    output logic      [2:0]  compCapTrimTwo,
    output logic      [1:0]  compCapTrimOne,
    output logic      [3:0]  compResTrimThree,
    output logic      [4:0]  compResTrimTwo,
    output logic      [2:0]  compResTrimOne,
    output logic      [6:0]  lowNoiseReferenceTrim,
    output logic             lowNoiseFeedbackAttenuation,
    output logic      [1:0]  biasDutyClockSelect,
    output logic      [7:0]  bypassEntryWait,
    output logic      [4:0]  lowNoiseInitWait,
    output logic             compPrechargeOn,
    output logic      [7:0]  lowPowerInitWait
);

    // ************************************************************
    // Storage. Every field is loaded with its reset value only by rst, which carries the
    // power-on, pin and brown-out sources and no other.
    // ************************************************************
    logic [2:0]  reverseCurrentLimitLevel;
    logic        forceContinuousConductionLn;
    logic        lowPowerOperation;
    logic        wrPending;
    logic [11:0] wrAddr;

    // ************************************************************
    // Bus decode. The slave always answers in zero wait states.
    // ************************************************************
    wire         addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    wire         rdPhase   = addrPhase && !hwrite;
    wire         wrZdet    = wrPending && wrAddr == ZDET_OFFSET;
    wire         wrClim    = wrPending && wrAddr == CLIM_OFFSET;
    wire         wrComp    = wrPending && wrAddr == COMP_OFFSET;
    wire         wrLnv     = wrPending && wrAddr == LNV_OFFSET;
    wire         wrTiming  = wrPending && wrAddr == TIMING_OFFSET;
    wire         wrMode    = wrPending && wrAddr == MODE_OFFSET;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Read images; reserved bits read as zero.
    wire [31:0] zdetImage   = {22'h0, zeroDetectBlankDelay, 1'b0, reverseCurrentLimitLevel, 4'h0};
    wire [31:0] climImage   = {18'h0, bypassCurrentLimitOn, 3'h0, currentLimitBlankDelay, 8'h00};
    wire [31:0] compImage   = {compCapTrimThree, 1'b0, compCapTrimTwo, 2'h0, compCapTrimOne,
                               4'h0, compResTrimThree, 3'h0, compResTrimTwo, 1'b0,
                               compResTrimOne};
    wire [31:0] lnvImage    = {17'h0, lowNoiseReferenceTrim, 6'h00,
                               lowNoiseFeedbackAttenuation, 1'b0};
    wire [31:0] timingImage = {1'b0, biasDutyClockSelect, 1'b0, bypassEntryWait, 3'h0,
                               lowNoiseInitWait, compPrechargeOn, 3'h0, lowPowerInitWait};
    wire [31:0] modeImage   = {30'h0, lowPowerOperation, forceContinuousConductionLn};
    wire [31:0] readMux     = (haddr == ZDET_OFFSET)   ? zdetImage   :
                              (haddr == CLIM_OFFSET)   ? climImage   :
                              (haddr == COMP_OFFSET)   ? compImage   :
                              (haddr == LNV_OFFSET)    ? lnvImage    :
                              (haddr == TIMING_OFFSET) ? timingImage :
                              (haddr == MODE_OFFSET)   ? modeImage   : 32'h0000_0000;

    // Capture the write address phase; data follows one cycle later.
    always_ff @(posedge clk) begin
        if (rst) begin
            wrPending <= 1'b0;
            wrAddr    <= 12'h000;
        end else begin
            wrPending <= addrPhase && hwrite;
            wrAddr    <= haddr;
        end
    end

    // Read data registered at the address phase, so it stands in the data phase.
    always_ff @(posedge clk) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (rdPhase) begin
            hrdata <= readMux;
        end
    end

    // ************************************************************
    // Zero detector and current limiter registers.
    // ************************************************************
    // Blanking delays are stored as written; software is trusted to leave them. [R14]
    always_ff @(posedge clk) begin
        if (rst) begin                                            // [R12]
            reverseCurrentLimitLevel <= ZDET_LEVEL_RESET;         // [R4]
            zeroDetectBlankDelay     <= ZDET_BLANK_RESET;
            bypassCurrentLimitOn     <= CLIM_BYP_RESET;
            currentLimitBlankDelay   <= CLIM_BLANK_RESET;
        end else begin
            if (wrZdet) begin
                reverseCurrentLimitLevel <= hwdata[ZDET_LEVEL_LSB +: 3]; // [R4]
                zeroDetectBlankDelay     <= hwdata[ZDET_BLANK_LSB +: 2]; // [R14]
            end
            if (wrClim) begin
                bypassCurrentLimitOn   <= hwdata[CLIM_BYP_BIT];
                currentLimitBlankDelay <= hwdata[CLIM_BLANK_LSB +: 2];
            end
        end
    end

    // ************************************************************
    // Compensator trims.
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin                                            // [R12]
            compCapTrimThree <= COMP_C3_RESET;                    // [R7]
            compCapTrimTwo   <= COMP_C2_RESET;
            compCapTrimOne   <= COMP_C1_RESET;
            compResTrimThree <= COMP_R3_RESET;                    // [R8]
            compResTrimTwo   <= COMP_R2_RESET;
            compResTrimOne   <= COMP_R1_RESET;
        end else if (wrComp) begin
            compCapTrimThree <= hwdata[COMP_C3_LSB +: 4];         // [R7]
            compCapTrimTwo   <= hwdata[COMP_C2_LSB +: 3];
            compCapTrimOne   <= hwdata[COMP_C1_LSB +: 2];
            compResTrimThree <= hwdata[COMP_R3_LSB +: 4];         // [R8]
            compResTrimTwo   <= hwdata[COMP_R2_LSB +: 5];
            compResTrimOne   <= hwdata[COMP_R1_LSB +: 3];
        end
    end

    // ************************************************************
    // Low-noise voltage. A hardware load of the reference wins over a
    // software write in the same cycle, since calibration must not be lost.
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin                                            // [R12]
            lowNoiseReferenceTrim       <= LNV_REF_RESET;         // [R9]
            lowNoiseFeedbackAttenuation <= LNV_ATT_RESET;         // [R11]
        end else begin
            if (refTrimLoad) begin
                lowNoiseReferenceTrim <= refTrimValue;            // [R9]
            end else if (wrLnv) begin
                lowNoiseReferenceTrim <= hwdata[LNV_REF_LSB +: 7]; // [R10]
            end
            if (wrLnv) begin
                lowNoiseFeedbackAttenuation <= hwdata[LNV_ATT_BIT]; // [R11]
            end
        end
    end

    // ************************************************************
    // Controller timing and operating mode.
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin                                            // [R12]
            biasDutyClockSelect         <= TIM_DUTY_RESET;
            bypassEntryWait             <= TIM_BYP_RESET;
            lowNoiseInitWait            <= TIM_LN_RESET;
            compPrechargeOn             <= TIM_PRCHG_RESET;       // [R14]
            lowPowerInitWait            <= TIM_LPINIT_RESET;
            forceContinuousConductionLn <= MODE_CCM_RESET;
            lowPowerOperation           <= MODE_LP_RESET;
        end else begin
            if (wrTiming) begin
                biasDutyClockSelect <= hwdata[TIM_DUTY_LSB +: 2];
                bypassEntryWait     <= hwdata[TIM_BYP_LSB +: 8];
                lowNoiseInitWait    <= hwdata[TIM_LN_LSB +: 5];
                compPrechargeOn     <= hwdata[TIM_PRCHG_BIT];
                lowPowerInitWait    <= hwdata[TIM_LPINIT_LSB +: 8];
            end
            if (wrMode) begin
                forceContinuousConductionLn <= hwdata[MODE_CCM_BIT];
                lowPowerOperation           <= hwdata[MODE_LP_BIT];
            end
        end
    end

    // ************************************************************
    // Zero detector steering. Low power overrides everything, and a
    // limiter at level zero is reported as discontinuous conduction.
    // ************************************************************
    wire limiterActive = forceContinuousConductionLn && !lowPowerOperation;  // [R1] [R3]

    assign zeroDetectMode       = limiterActive ? DCRC_ZD_LIMITER : DCRC_ZD_CROSSING; // [R2]
    assign reverseCurrentLimit  = limiterActive ? reverseCurrentLimitLevel : 3'h0;  // [R4]
    assign continuousConduction = 1'b0;  // Limiter or not, the converter stays in DISCONTINUOUS_CONDUCTION. [R2] [R5]

    // ************************************************************
    // Checks.
    // ************************************************************
    zdet_lp_a: assert property (@(posedge clk) disable iff (rst)
        lowPowerOperation |-> zeroDetectMode == DCRC_ZD_CROSSING && reverseCurrentLimit == 3'h0)
        else $error("Low-power mode must use crossing detection."); // [R3]
    zdet_ln_a: assert property (@(posedge clk) disable iff (rst)
        !lowPowerOperation && !forceContinuousConductionLn |-> reverseCurrentLimit == 3'h0)
        else $error("Limit must be zero without force-continuous."); // [R1]
    zdet_lim_a: assert property (@(posedge clk) disable iff (rst)
        limiterActive |-> zeroDetectMode == DCRC_ZD_LIMITER
                          && reverseCurrentLimit == reverseCurrentLimitLevel)
        else $error("Limiter must use the level field."); // [R2]
    zdet_write_a: assert property (@(posedge clk) disable iff (rst)
        wrZdet |=> reverseCurrentLimitLevel == $past(hwdata[6:4]))
        else $error("Level field write lost."); // [R4]
    dcm_only_a: assert property (@(posedge clk) disable iff (rst)
        continuousConduction == 1'b0)
        else $error("Converter left discontinuous conduction."); // [R5]
    comp_write_a: assert property (@(posedge clk) disable iff (rst)
        wrComp |=> compCapTrimThree == $past(hwdata[31:28])
                   && compResTrimThree == $past(hwdata[15:12]))
        else $error("Compensator trim write lost."); // [R7]
    res_hold_a: assert property (@(posedge clk) disable iff (rst)
        !wrComp |=> $stable(compResTrimTwo) && $stable(compResTrimOne))
        else $error("Resistor trim changed without a write."); // [R8]
    ref_hw_a: assert property (@(posedge clk) disable iff (rst)
        refTrimLoad |=> lowNoiseReferenceTrim == $past(refTrimValue))
        else $error("Hardware reference load lost."); // [R9]
    att_write_a: assert property (@(posedge clk) disable iff (rst)
        wrLnv |=> lowNoiseFeedbackAttenuation == $past(hwdata[1]))
        else $error("Attenuation write lost."); // [R11]
    reset_val_a: assert property (@(posedge clk)
        rst |=> compCapTrimThree == 4'h5 && lowNoiseReferenceTrim == 7'h71
                && reverseCurrentLimitLevel == 3'h3 && !lowNoiseFeedbackAttenuation)
        else $error("Reset values wrong."); // [R12]
    hold_int_a: assert property (@(posedge clk) disable iff (rst)
        !wrTiming |=> $stable(compPrechargeOn))
        else $error("Precharge enable changed without a write."); // [R14]

    limiter_c: cover property (@(posedge clk) disable iff (rst)
        limiterActive && reverseCurrentLimitLevel == 3'h7);
    lp_override_c: cover property (@(posedge clk) disable iff (rst)
        forceContinuousConductionLn && lowPowerOperation);
    ref_clash_c: cover property (@(posedge clk) disable iff (rst) refTrimLoad && wrLnv);

endmodule

/* test_dcdc_regulator_control_regs.sv */
/*
 * Self-checking bench for the buck regulator control registers: reset values, read-back of
 * random writes, zero detector steering, hardware trim loads and a reset in mid-run.
 * Assumes dcrc_pkg and dcrc_regs are compiled first and that the slave answers with zero
 * wait states, so hready is looped back from hreadyout.
 */
`timescale 1ns/10ps

`define CHK(nm, e, g) begin samples_checked++; if ((e) !== (g)) begin n_mismatch++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end

module test_dcdc_regulator_control_regs import dcrc_pkg::*;
();
    logic          clk = 1'b0;
    logic          rst = 1'b1;
    logic          hsel = 1'b0;
    logic   [11:0] haddr = 12'h000;
    logic   [1:0]  htrans = 2'h0;
    logic          hwrite = 1'b0;
    logic   [2:0]  hsize = 3'h2;
    logic   [31:0] hwdata = 32'h00000000;
    wire           hready;
    logic   [31:0] hrdata;
    logic          hreadyout;
    logic          hresp;
    logic          refTrimLoad = 1'b0;
    logic   [6:0]  refTrimValue = 7'h00;
    dcrc_zdet_type zeroDetectMode;
    logic   [2:0]  reverseCurrentLimit, compCapTrimTwo, compResTrimOne;
    logic          continuousConduction, bypassCurrentLimitOn, lowNoiseFeedbackAttenuation;
    logic   [1:0]  zeroDetectBlankDelay, currentLimitBlankDelay, compCapTrimOne;
    logic   [3:0]  compCapTrimThree, compResTrimThree;
    logic   [4:0]  compResTrimTwo, lowNoiseInitWait;
    logic   [6:0]  lowNoiseReferenceTrim;
    logic   [1:0]  biasDutyClockSelect;
    logic   [7:0]  bypassEntryWait, lowPowerInitWait;
    logic          compPrechargeOn;
    logic          readPhase = 1'b0;
    logic   [31:0] rdq[$];
    logic   [11:0] offs[6];
    logic   [31:0] masks[6];
    logic   [31:0] rv[6];
    int            n_mismatch = 0;
    int            samples_checked = 0;
    int            cycles = 0;
    logic   [31:0] rdExp;

    // Field outputs packed at their register positions, so whole words can be compared.
    wire    [31:0] climOut = {18'h0, bypassCurrentLimitOn, 3'h0, currentLimitBlankDelay, 8'h00};
    wire    [31:0] compOut = {compCapTrimThree, 1'b0, compCapTrimTwo, 2'h0, compCapTrimOne, 4'h0,
                              compResTrimThree, 3'h0, compResTrimTwo, 1'b0, compResTrimOne};
    wire    [31:0] timOut  = {1'b0, biasDutyClockSelect, 1'b0, bypassEntryWait, 3'h0,
                              lowNoiseInitWait, compPrechargeOn, 3'h0, lowPowerInitWait};

    // ************************************************************
    // Clock, loop-back of ready, and the design.
    // ************************************************************
    always #10 clk = ~clk;
    assign hready = hreadyout;

    dcrc_regs i_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .refTrimLoad(refTrimLoad),
        .refTrimValue(refTrimValue), .zeroDetectMode(zeroDetectMode),
        .reverseCurrentLimit(reverseCurrentLimit), .continuousConduction(continuousConduction),
        .bypassCurrentLimitOn(bypassCurrentLimitOn), .zeroDetectBlankDelay(zeroDetectBlankDelay),
        .currentLimitBlankDelay(currentLimitBlankDelay), .compCapTrimThree(compCapTrimThree),
        .compCapTrimTwo(compCapTrimTwo), .compCapTrimOne(compCapTrimOne),
        .compResTrimThree(compResTrimThree), .compResTrimTwo(compResTrimTwo),
        .compResTrimOne(compResTrimOne), .lowNoiseReferenceTrim(lowNoiseReferenceTrim),
        .lowNoiseFeedbackAttenuation(lowNoiseFeedbackAttenuation),
        .biasDutyClockSelect(biasDutyClockSelect), .bypassEntryWait(bypassEntryWait),
        .lowNoiseInitWait(lowNoiseInitWait), .compPrechargeOn(compPrechargeOn),
        .lowPowerInitWait(lowPowerInitWait));

    // ************************************************************
    // Bus master tasks. Each transfer starts just after an edge and holds until hready.
    // ************************************************************
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Waits for ready however long it takes; only the bench timeout ends a hang.
    task automatic busWait();
        @(posedge clk);
        while (hready !== 1'b1) begin
            @(posedge clk);
        end
    endtask

    task automatic busWrite(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        busWait();
        htrans <= 2'h0;
        hwdata <= d;
        busWait();
    endtask

    // The expected word is queued here; the watcher below compares it at the data edge.
    task automatic busRead(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= 1'b0;
        htrans <= HTRANS_NONSEQ;
        busWait();
        htrans <= 2'h0;
        rdq.push_back(e);
        readPhase <= 1'b1;
        busWait();
        readPhase <= 1'b0;
    endtask

    // Reads every register against its reset word and checks a few field outputs.
    task automatic checkResetAll();
        for (int i = 0; i < 6; i++) begin
            busRead(offs[i], rv[i]);
        end
        `CHK("refTrim", LNV_REF_RESET, lowNoiseReferenceTrim)
        `CHK("attenuation", LNV_ATT_RESET, lowNoiseFeedbackAttenuation)
        `CHK("limit", 3'h0, reverseCurrentLimit)
        `CHK("blankDelay", ZDET_BLANK_RESET, zeroDetectBlankDelay)
        `CHK("climOut", rv[1], climOut)
        `CHK("compOut", rv[2], compOut)
        `CHK("timingOut", rv[4], timOut)
    endtask

    // ************************************************************
    // Watcher: takes the oldest expected word whenever read data stands.
    // ************************************************************
    always @(posedge clk) begin
        // The note is popped once, since the compare macro reads its argument twice.
        if (readPhase === 1'b1) begin
            rdExp = rdq.pop_front();
            `CHK("hrdata", rdExp, hrdata)
            `CHK("hresp", 1'b0, hresp)
        end
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            results();
        end
    end

    // ************************************************************
    // Main sequence.
    // ************************************************************
    initial begin
        logic [31:0] w;
        logic [2:0]  lvls[3];
        logic [2:0]  expLim;
        logic [1:0]  expMode;
        w = $urandom(32'h97ca);
        lvls = '{3'h0, 3'h3, 3'h7}; // Level 7 is the largest a sane limit calculation yields.
        offs = '{ZDET_OFFSET, CLIM_OFFSET, COMP_OFFSET, LNV_OFFSET, TIMING_OFFSET, MODE_OFFSET};
        masks = '{32'h00000370, 32'h00002300, 32'hf730f1f7, 32'h00007f02, 32'h6ff1f8ff,
                  32'h00000003};
        rv[0] = (32'(ZDET_LEVEL_RESET) << ZDET_LEVEL_LSB) | (32'(ZDET_BLANK_RESET) << 8);
        rv[1] = (32'(CLIM_BYP_RESET) << CLIM_BYP_BIT) | (32'(CLIM_BLANK_RESET) << 8);
        rv[2] = (32'(COMP_C3_RESET) << 28) | (32'(COMP_C2_RESET) << 24)
              | (32'(COMP_C1_RESET) << 20) | (32'(COMP_R3_RESET) << 12)
              | (32'(COMP_R2_RESET) << 4) | 32'(COMP_R1_RESET);
        rv[3] = (32'(LNV_REF_RESET) << LNV_REF_LSB) | (32'(LNV_ATT_RESET) << LNV_ATT_BIT);
        rv[4] = (32'(TIM_DUTY_RESET) << 29) | (32'(TIM_BYP_RESET) << 20)
              | (32'(TIM_LN_RESET) << 12) | (32'(TIM_PRCHG_RESET) << 11) | 32'(TIM_LPINIT_RESET);
        rv[5] = 32'h00000000;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        checkResetAll();
        busWrite(12'h0a0, 32'hffffffff);
        busRead(12'h0a0, 32'h00000000);
        // Random words, reserved bits kept zero, then read back and seen on the fields.
        for (int i = 0; i < 5; i++) begin
            w = $urandom() & masks[i];
            busWrite(offs[i], w);
            busRead(offs[i], w);
            #1;
            if (i == 1) `CHK("climOut", w, climOut)
            if (i == 2) `CHK("compOut", w, compOut)
            if (i == 4) `CHK("timingOut", w, timOut)
            if (i == 2) `CHK("capThree", w[31:28], compCapTrimThree)
            if (i == 2) `CHK("resThree", w[15:12], compResTrimThree)
            if (i == 3) `CHK("refTrimOut", w[14:8], lowNoiseReferenceTrim)
            if (i == 3) `CHK("attOut", w[1], lowNoiseFeedbackAttenuation)
        end
        // Zero detector steering over every operation and conduction choice, at levels 0, 3 and 7.
        for (int m = 0; m < 4; m++) begin
            for (int j = 0; j < 3; j++) begin
                busWrite(ZDET_OFFSET, 32'(lvls[j]) << ZDET_LEVEL_LSB);
                busWrite(MODE_OFFSET, 32'(m));
                #1;
                expMode = (m == 1) ? DCRC_ZD_LIMITER : DCRC_ZD_CROSSING;
                expLim = (m == 1) ? lvls[j] : 3'h0;
                `CHK("zdetMode", expMode, zeroDetectMode)
                `CHK("limit", expLim, reverseCurrentLimit)
                `CHK("continuous", 1'b0, continuousConduction)
            end
        end
        // Hardware load of the reference trim keeps the attenuation bit.
        busWrite(LNV_OFFSET, 32'h00000002);
        w = $urandom() & 32'h7f;
        @(posedge clk);
        refTrimValue <= w[6:0];
        refTrimLoad <= 1'b1;
        @(posedge clk);
        refTrimLoad <= 1'b0;
        busRead(LNV_OFFSET, (w << 8) | 32'h2);
        #1;
        `CHK("hwTrim", w[6:0], lowNoiseReferenceTrim)
        // Fill every register, then reset in mid-run and expect defaults again.
        for (int i = 0; i < 6; i++) begin
            busWrite(offs[i], masks[i]);
        end
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        checkResetAll();
        repeat (2) @(posedge clk);
        results();
    end
endmodule
